// file: rtl/serial_slave.sv
// Purpose: two-wire slave writing two control bytes, reading one status byte
// Assumes: master drives every clock pulse; lines have external pull-ups
// Notes:   latched status clears only after master acknowledges status data
// Behaviour
// RQ1 - both lines open-drain; pull low or release only; idle both high
// RQ2 - master makes all clock pulses; slave never drives clock
// RQ3 - data changes only while clock low, except start and stop
// RQ4 - device acknowledges eight received address or data bits on ninth pulse
// RQ5 - master acknowledges status byte on ninth pulse
// RQ6 - receiver without valid byte leaves data high on ninth pulse
// RQ7 - write: acknowledge chip address, control index, control data
// RQ8 - read: device acks address, index, repeated address; master acks data
// RQ9 - start is data falling while clock high; begins a transaction
// RQ10 - stop is data rising while clock high; ends a transaction
// RQ11 - start or stop mid-byte abandons transfer and restarts sequence
// RQ12 - chip address MSB first: 00010 plus two select bits
// RQ13 - control indices 0 and 1 accepted; status index 0
// RQ14 - latched faults stay until status read acknowledged by master
// RQ15 - lines synchronised and glitch filtered before edge detection
`timescale 1ns/10ps
module serial_slave
  import serial_slave_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // bus lines
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // address select
  input  wire logic [1:0] addr_sel,
  // device side
  input  wire logic [7:0] status_live,
  input  wire logic [7:0] status_latch_set,
  output logic [7:0]      control0,
  output logic [7:0]      control1,
  output logic [7:0]      status_latched,
  output logic            status_read_done
);
  import serial_slave_pkg::*;

  logic scl_f;
  logic sda_f;

  line_filter u_scl (
    .clk      (clk),
    .reset_n  (reset_n),
    .line_in  (scl_in),
    .line_out (scl_f)
  );

  line_filter u_sda (
    .clk      (clk),
    .reset_n  (reset_n),
    .line_in  (sda_in),
    .line_out (sda_f)
  );

  // ************************************************************
  // edge and condition detection
  // ************************************************************
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_d_r;
  assign scl_fall = ~scl_f & scl_d_r;
  assign start_c  = scl_f & scl_d_r & sda_d_r & ~sda_f; // RQ9
  assign stop_c   = scl_f & scl_d_r & ~sda_d_r & sda_f; // RQ10

  // ************************************************************
  // transfer sequencer
  // ************************************************************
  slave_state_e state_r;
  slave_state_e state_nxt;
  logic [3:0]   bitcnt_r;
  logic [3:0]   bitcnt_nxt;
  logic [7:0]   shift_r;
  logic [7:0]   shift_nxt;
  logic [7:0]   index_r;
  logic [7:0]   index_nxt;
  logic         ack_r;
  logic         ack_nxt;
  logic         drive_r;
  logic         drive_nxt;
  logic         rd_ok_r;
  logic         rd_ok_nxt;
  logic [7:0]   ctl0_r;
  logic [7:0]   ctl0_nxt;
  logic [7:0]   ctl1_r;
  logic [7:0]   ctl1_nxt;
  logic         done_r;
  logic         done_nxt;
  logic [7:0]   tx_r;
  logic [7:0]   tx_nxt;
  logic [6:0]   my_addr;

  assign my_addr = {ADDR_FIXED, addr_sel}; // RQ12

  always_comb begin
    state_nxt  = state_r;
    bitcnt_nxt = bitcnt_r;
    shift_nxt  = shift_r;
    index_nxt  = index_r;
    ack_nxt    = ack_r;
    drive_nxt  = drive_r;
    rd_ok_nxt  = rd_ok_r;
    ctl0_nxt   = ctl0_r;
    ctl1_nxt   = ctl1_r;
    done_nxt   = 1'b0;
    tx_nxt     = tx_r;
    if (start_c) begin // RQ11
      state_nxt  = ST_ADDR;
      bitcnt_nxt = BIT_PRE;
      drive_nxt  = 1'b0;
      ack_nxt    = 1'b0;
    end else if (stop_c) begin // RQ11
      state_nxt = ST_IDLE;
      drive_nxt = 1'b0;
      ack_nxt   = 1'b0;
    end else if (scl_rise && state_r != ST_IDLE && state_r != ST_SKIP) begin
      if (bitcnt_r <= BIT_LAST) begin
        shift_nxt = {shift_r[6:0], sda_f};
      end else if (state_r == ST_RDATA && !sda_f) begin // RQ5
        done_nxt = 1'b1; // RQ14
      end
    end else if (scl_fall) begin
      case (state_r)
        ST_IDLE, ST_SKIP: begin
          drive_nxt = 1'b0;
        end
        ST_RDATA: begin
          if (bitcnt_r == BIT_ACK) begin
            state_nxt = ST_SKIP;
            drive_nxt = 1'b0;
          end else begin
            bitcnt_nxt = bitcnt_r + 4'h1;
            drive_nxt  = (bitcnt_r < BIT_LAST) & ~tx_r[3'(BIT_LAST - 4'h1 - bitcnt_r)];
            tx_nxt     = tx_r;
          end
        end
        default: begin
          if (bitcnt_r == BIT_LAST) begin
            bitcnt_nxt = BIT_ACK;
            ack_nxt    = 1'b0;
            case (state_r)
              ST_ADDR: begin
                if (shift_r[7:1] == my_addr) begin
                  if (shift_r[0]) begin
                    ack_nxt = rd_ok_r; // RQ8
                  end else begin
                    ack_nxt = 1'b1; // RQ7
                  end
                end
              end
              ST_INDEX: begin
                ack_nxt = 1'b1;
              end
              default: begin
                ack_nxt = (index_r == CTRL_IDX0) | (index_r == CTRL_IDX1); // RQ13
              end
            endcase
            drive_nxt = ack_nxt; // RQ4 RQ6
          end else if (bitcnt_r == BIT_ACK) begin
            drive_nxt  = 1'b0;
            bitcnt_nxt = 4'h0;
            if (!ack_r) begin
              state_nxt = ST_SKIP; // RQ6
            end else begin
              case (state_r)
                ST_ADDR: begin
                  if (shift_r[0]) begin
                    state_nxt = ST_RDATA;
                    tx_nxt    = status_live | status_latched;
                    drive_nxt = ~(status_live[7] | status_latched[7]);
                    rd_ok_nxt = 1'b0;
                  end else begin
                    state_nxt = ST_INDEX;
                  end
                end
                ST_INDEX: begin
                  index_nxt = shift_r;
                  rd_ok_nxt = (shift_r == STAT_IDX); // RQ13
                  state_nxt = ST_WDATA;
                end
                ST_WDATA: begin
                  if (index_r == CTRL_IDX0) begin
                    ctl0_nxt = shift_r;
                  end else if (index_r == CTRL_IDX1) begin
                    ctl1_nxt = shift_r;
                  end
                  state_nxt = ST_SKIP;
                end
                default: begin
                  state_nxt = ST_SKIP;
                end
              endcase
            end
          end else begin
            bitcnt_nxt = bitcnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r  <= ST_IDLE;
      bitcnt_r <= 4'h0;
      shift_r  <= 8'h00;
      index_r  <= 8'h00;
      ack_r    <= 1'b0;
      drive_r  <= 1'b0;
      rd_ok_r  <= 1'b0;
      ctl0_r   <= CTRL_RST;
      ctl1_r   <= CTRL_RST;
      done_r   <= 1'b0;
      tx_r     <= 8'h00;
    end else begin
      state_r  <= state_nxt;
      bitcnt_r <= bitcnt_nxt;
      shift_r  <= shift_nxt;
      index_r  <= index_nxt;
      ack_r    <= ack_nxt;
      drive_r  <= drive_nxt;
      rd_ok_r  <= rd_ok_nxt;
      ctl0_r   <= ctl0_nxt;
      ctl1_r   <= ctl1_nxt;
      done_r   <= done_nxt;
      tx_r     <= tx_nxt;
    end
  end

  // ************************************************************
  // latched status bits
  // ************************************************************
  logic [7:0] latch_r;
  logic [7:0] latch_nxt;

  always_comb begin
    latch_nxt = latch_r;
    if (done_nxt) begin
      latch_nxt = 8'h00; // RQ14
    end
    latch_nxt = latch_nxt | status_latch_set;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_r <= 8'h00;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // data line only pulled low, clock never driven
  assign sda_out          = 1'b0; // RQ1 RQ2
  assign sda_oe           = drive_r; // RQ3
  assign control0         = ctl0_r;
  assign control1         = ctl1_r;
  assign status_latched   = latch_r;
  assign status_read_done = done_r;

  // ************************************************************
  // assertions
  // ************************************************************
  AST_NO_DRIVE_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
    (state_r == ST_IDLE) |-> !sda_oe) else $error("drives line while idle"); // RQ1
  AST_OE_CHANGES_LOW: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(sda_oe) && !$past(start_c) && !$past(stop_c) |-> !scl_d_r)
    else $error("data drive changed with clock high"); // RQ3
  AST_START_RESTART: assert property (@(posedge clk) disable iff (!reset_n)
    start_c |=> state_r == ST_ADDR && bitcnt_r == BIT_PRE) else $error("start not taken"); // RQ9
  AST_STOP_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
    stop_c && !start_c |=> state_r == ST_IDLE) else $error("stop not taken"); // RQ10
  AST_ACK_ON_NINTH: assert property (@(posedge clk) disable iff (!reset_n)
    scl_fall && !start_c && !stop_c && bitcnt_r == BIT_LAST
      && state_r == ST_INDEX |=> sda_oe) else $error("index byte not acked"); // RQ4
  AST_BAD_ADDR_NAK: assert property (@(posedge clk) disable iff (!reset_n)
    scl_fall && !start_c && !stop_c && bitcnt_r == BIT_LAST && state_r == ST_ADDR
      && shift_r[7:1] != my_addr |=> !sda_oe) else $error("foreign address acked"); // RQ6
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    !done_nxt |=> (latch_r & $past(latch_r)) == $past(latch_r))
    else $error("latched bit lost"); // RQ14
  AST_CLEAR_AFTER_ACK: assert property (@(posedge clk) disable iff (!reset_n)
    done_r |-> latch_r == $past(status_latch_set)) else $error("latch not cleared"); // RQ14
  AST_CTRL_STABLE: assert property (@(posedge clk) disable iff (!reset_n)
    state_r != ST_WDATA |=> $stable(ctl0_r) && $stable(ctl1_r))
    else $error("control written outside data byte"); // RQ7

  COV_WRITE0: cover property (@(posedge clk) disable iff (!reset_n) $changed(ctl0_r));
  COV_WRITE1: cover property (@(posedge clk) disable iff (!reset_n) $changed(ctl1_r));
  COV_READ:   cover property (@(posedge clk) disable iff (!reset_n) done_r);
  COV_ABORT:  cover property (@(posedge clk) disable iff (!reset_n)
    start_c && state_r == ST_INDEX);
endmodule

// file: rtl/serial_slave_pkg.sv
// Purpose: constants for the two-wire control/status slave
// Assumes: 20 MHz system clock, link lines sampled as plain inputs
// Notes:   shared by the slave core and its line filter
package serial_slave_pkg;
  localparam int          SYNC_STAGES    = 2;
  localparam int          FILT_LEN       = 3;
  localparam logic [4:0]  ADDR_FIXED     = 5'h02;
  localparam logic [7:0]  CTRL_IDX0      = 8'h00;
  localparam logic [7:0]  CTRL_IDX1      = 8'h01;
  localparam logic [7:0]  STAT_IDX       = 8'h00;
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  localparam logic [3:0]  BIT_LAST       = 4'h7;
  localparam logic [3:0]  BIT_ACK        = 4'h8;
  // count after start; the fall that follows a start wraps it to 0
  localparam logic [3:0]  BIT_PRE        = 4'hF;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_ADDR  = 6'b000010,
    ST_INDEX = 6'b000100,
    ST_WDATA = 6'b001000,
    ST_RDATA = 6'b010000,
    ST_SKIP  = 6'b100000
  } slave_state_e;
endpackage

// file: rtl/line_filter.sv
// Purpose: synchronise and deglitch one bus line
// Assumes: line idles high
// Notes:   output changes only after FILT_LEN equal samples
`timescale 1ns/10ps
module line_filter
  import serial_slave_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // line
  input  wire logic line_in,
  output logic      line_out
);
  logic [SYNC_STAGES-1:0] sync_r;
  logic [FILT_LEN-1:0]    hist_r;
  logic [FILT_LEN-1:0]    hist_nxt;
  logic                   out_r;
  logic                   out_nxt;

  always_comb begin
    hist_nxt = {hist_r[FILT_LEN-2:0], sync_r[SYNC_STAGES-1]};
    out_nxt  = out_r;
    if (&hist_r) begin // RQ15
      out_nxt = 1'b1;
    end else if (~|hist_r) begin
      out_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_r <= '1;
      hist_r <= '1;
      out_r  <= 1'b1;
    end else begin
      sync_r <= {sync_r[SYNC_STAGES-2:0], line_in};
      hist_r <= hist_nxt;
      out_r  <= out_nxt;
    end
  end

  assign line_out = out_r;
endmodule

// file: testbench/bus_master.sv
// Purpose: two-wire bus master model, makes every clock pulse
// Assumes: open-drain lines with pull-ups; 20 MHz bench clock
// Notes:   line changes land by non-blocking assignment at clk rise
`timescale 1ns/10ps
module bus_master (
  // clock
  input  wire logic clk,
  // lines
  input  wire logic slave_oe,
  output logic      scl,
  output logic      sda
);
  logic scl_pull = 1'b0;
  logic sda_pull = 1'b0;
  // ****************
  // wired lines
  // ****************
  assign scl = ~scl_pull;
  assign sda = ~(sda_pull | slave_oe);
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ****************
  // bus cycles
  // ****************
  task automatic pulse(input logic b, output logic s);
    scl_pull <= 1'b1;
    wt(8);
    sda_pull <= ~b;
    wt(4);
    scl_pull <= 1'b0;
    wt(4);
    s = sda;
    wt(4);
  endtask
  task automatic start;
    scl_pull <= 1'b1;
    wt(4);
    sda_pull <= 1'b0;
    wt(4);
    scl_pull <= 1'b0;
    wt(8);
    sda_pull <= 1'b1;
    wt(8);
  endtask
  task automatic stop;
    scl_pull <= 1'b1;
    wt(4);
    sda_pull <= 1'b1;
    wt(4);
    scl_pull <= 1'b0;
    wt(8);
    sda_pull <= 1'b0;
    wt(8);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(d[i], s);
    end
    pulse(1'b1, s);
    ack = ~s;
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, d[i]);
    end
    pulse(~mack, s);
  endtask
endmodule

// file: testbench/tb.sv
// Purpose: self-checking bench for the two-wire control/status slave
// Assumes: bus master model on the far side of the lines
// Notes:   acks returned as bit vectors, chip address first
`timescale 1ns/10ps
module tb;
  import serial_slave_pkg::*;
  logic       clk              = 1'b0;
  logic       reset_n          = 1'b0;
  logic [1:0] addr_sel         = 2'h2;
  logic [7:0] status_live      = 8'h00;
  logic [7:0] status_latch_set = 8'h00;
  logic       scl;
  logic       sda;
  logic       sda_out;
  logic       sda_oe;
  logic       status_read_done;
  logic [7:0] control0;
  logic [7:0] control1;
  logic [7:0] status_latched;
  int         err_count        = 0;
  int         checked          = 0;
  logic [7:0] done_cnt         = 8'h00;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (status_read_done === 1'b1) begin
      done_cnt <= done_cnt + 8'h01;
    end
  end
  bus_master m (.clk(clk), .slave_oe(sda_oe & ~sda_out), .scl(scl), .sda(sda));
  serial_slave uut (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .status_live(status_live),
    .status_latch_set(status_latch_set), .control0(control0), .control1(control1),
    .status_latched(status_latched), .status_read_done(status_read_done));
  // ****************
  // shared tasks
  // ****************
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] caddr(input logic [1:0] s, input logic rw);
    return {5'h02, s, rw};
  endfunction
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d, output logic [2:0] a);
    m.start();
    m.wr_byte(caddr(addr_sel, 1'b0), a[2]);
    m.wr_byte(idx, a[1]);
    m.wr_byte(d, a[0]);
    m.stop();
  endtask
  task automatic rd_stat(input logic mack, output logic [7:0] d, output logic [2:0] a);
    m.start();
    m.wr_byte(caddr(addr_sel, 1'b0), a[2]);
    m.wr_byte(8'h00, a[1]);
    m.stop();
    m.start();
    m.wr_byte(caddr(addr_sel, 1'b1), a[0]);
    m.rd_byte(mack, d);
    m.stop();
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_write;
    logic [2:0] a;
    wr_reg(8'h00, 8'hA5, a);
    chk("write acks idx0", 8'h07, {5'h00, a});
    wr_reg(8'h01, 8'h3C, a);
    chk("write acks idx1", 8'h07, {5'h00, a});
    chk("control0", 8'hA5, control0);
    chk("control1", 8'h3C, control1);
  endtask
  task automatic t_refuse;
    logic [2:0] a;
    m.start();
    m.wr_byte(caddr(2'h1, 1'b0), a[0]);
    m.stop();
    chk("foreign address ack", 8'h00, {7'h00, a[0]});
    wr_reg(8'h02, 8'hFF, a);
    chk("bad index acks", 8'h06, {5'h00, a});
    chk("control0 kept", 8'hA5, control0);
    chk("control1 kept", 8'h3C, control1);
  endtask
  task automatic t_read;
    logic [2:0] a;
    logic [7:0] d;
    status_live <= 8'h40;
    status_latch_set <= 8'h08;
    m.wt(1);
    status_latch_set <= 8'h00;
    m.wt(2);
    chk("latched set", 8'h08, status_latched);
    rd_stat(1'b0, d, a);
    chk("read acks", 8'h07, {5'h00, a});
    chk("status nak", 8'h48, d);
    chk("latched after nak", 8'h08, status_latched);
    chk("done after nak", 8'h00, done_cnt);
    rd_stat(1'b1, d, a);
    chk("status ack", 8'h48, d);
    chk("done after ack", 8'h01, done_cnt);
    chk("latched after ack", 8'h00, status_latched);
  endtask
  task automatic t_abort;
    logic [2:0] a;
    logic       s;
    m.start();
    for (int i = 7; i >= 4; i--) begin
      m.pulse(1'(caddr(addr_sel, 1'b0) >> i), s);
    end
    m.stop();
    m.start();
    for (int i = 7; i >= 5; i--) begin
      m.pulse(1'(caddr(addr_sel, 1'b0) >> i), s);
    end
    wr_reg(8'h00, 8'h5A, a);
    chk("acks after abort", 8'h07, {5'h00, a});
    chk("control0 after abort", 8'h5A, control0);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    m.wt(10);
    t_write();
    t_refuse();
    t_read();
    t_abort();
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    end_of_test();
  end
endmodule
